//--- design/copro_defines.svh
`ifndef COPRO_DEFINES_SVH
`define COPRO_DEFINES_SVH
`define CP_INSTR_W 26
`define CP_LEN_W 4
`define CP_WORD_W 32
`define CP_LEN_IDLE 4'h0
`endif

//--- design/copro_pkg.sv
`default_nettype none
package copro_pkg;
    `include "copro_defines.svh"
    typedef logic [`CP_INSTR_W-1:0] instr_t;
    typedef logic [`CP_LEN_W-1:0] len_t;
    typedef logic [2*`CP_WORD_W-1:0] dword_t;
    typedef enum logic [1:0] {CP_IDLE, CP_DEC, CP_EXE} cp_state_e;
endpackage : copro_pkg
`default_nettype wire

//--- design/copro_if.sv
`default_nettype none
interface copro_if;
    import copro_pkg::*;
    instr_t copro_instruction_bus;
    logic instruction_hint_valid;
    logic issue_valid_confirm;
    logic core_decode_stall;
    logic core_execute_stall;
    logic lsu_execute_hold;
    logic lsu_memory_hold;
    logic core_cancel;
    logic core_flush;
    logic copro_execute_busy;
    logic copro_transfer_busy;
    logic copro_reject;
    len_t transfer_length;
    logic word_swap_flag;
    logic doubleword_flag;
    dword_t load_data_bus;
    dword_t store_data_bus;
    modport core (output copro_instruction_bus, instruction_hint_valid, issue_valid_confirm, core_decode_stall,
        core_execute_stall, lsu_execute_hold, lsu_memory_hold, core_cancel, core_flush, load_data_bus,
        input copro_execute_busy, copro_transfer_busy, copro_reject, transfer_length, word_swap_flag,
        doubleword_flag, store_data_bus);
    modport copro (input copro_instruction_bus, instruction_hint_valid, issue_valid_confirm, core_decode_stall,
        core_execute_stall, lsu_execute_hold, lsu_memory_hold, core_cancel, core_flush, load_data_bus,
        output copro_execute_busy, copro_transfer_busy, copro_reject, transfer_length, word_swap_flag,
        doubleword_flag, store_data_bus);
endinterface : copro_if
`default_nettype wire

//--- design/word_swap.sv
`default_nettype none
`include "copro_defines.svh"
module word_swap
    import copro_pkg::*;
#(
    parameter int W = `CP_WORD_W
) (
    // Data in
    input wire logic [2*W-1:0] din,
    input wire logic swap,
    // Data out
    output logic [2*W-1:0] dout
);
    always_comb begin
        dout = swap ? {din[W-1:0], din[2*W-1:W]} : din;
    end
endmodule : word_swap
`default_nettype wire

//--- design/copro_core_end.sv
`default_nettype none
`include "copro_defines.svh"
module copro_core_end
    import copro_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Core pipeline side
    input wire logic issue_valid,
    input var instr_t issue_instr,
    input wire logic decode_genuine,
    input wire logic internal_decode_hold,
    input wire logic execute_hold,
    input wire logic lsu_e_hold,
    input wire logic lsu_m_hold,
    input wire logic lockstep,
    input wire logic cancel_req,
    input wire logic flush_req,
    input var dword_t load_data_in,
    // Captured attributes and data
    output len_t attr_length,
    output logic attr_swap,
    output logic attr_double,
    output dword_t store_data_out,
    output logic reject_seen,
    // Link
    copro_if.core link
);
    logic dstall_q, dstall_d, estall_q, estall_d, valid_q, valid_d, cancel_q, cancel_d, flush_q, flush_d;
    logic lse_q, lse_d, lsm_q, lsm_d, hint_q, hint_d, rej_q, rej_d, busy_vd, busy_ve, swp_q, swp_d;
    logic dbl_q, dbl_d, swp_eff;
    instr_t instr_q, instr_d;
    len_t len_q, len_d;
    dword_t ld_q, ld_d, ld_sw, st_sw, st_q, st_d;

    // Swap flag follows captured value while decode is stalled
    assign swp_eff = dstall_q ? swp_q : link.word_swap_flag;

    word_swap u_ld (.din(load_data_in), .swap(swp_eff), .dout(ld_sw));
    word_swap u_st (.din(link.store_data_bus), .swap(swp_eff), .dout(st_sw));

    always_comb begin
        instr_d = issue_valid ? issue_instr : '0;
        hint_d = issue_valid;
        valid_d = decode_genuine && !flush_req;
        // Busy counts only when the stall it would block is not already up
        busy_vd = link.copro_execute_busy && !dstall_q;
        busy_ve = link.copro_execute_busy && !estall_q;
        // Busy reaches the stalls only through their flops, so no combinational hold loop
        estall_d = (execute_hold || ((lsu_e_hold || lsu_m_hold) && lockstep))
            && !busy_ve && !flush_req;
        dstall_d = (internal_decode_hold || estall_d) && !busy_vd && !flush_req;
        lse_d = lsu_e_hold || lsu_m_hold;
        lsm_d = lsu_m_hold;
        cancel_d = estall_q ? cancel_q : cancel_req;
        flush_d = flush_req;
        // Capture attributes on the edge that raises the decode stall
        len_d = (dstall_d && !dstall_q) ? link.transfer_length : len_q;
        swp_d = (dstall_d && !dstall_q) ? link.word_swap_flag : swp_q;
        dbl_d = (dstall_d && !dstall_q) ? link.doubleword_flag : dbl_q;
        rej_d = link.copro_reject && !estall_q && !dstall_q && !lsu_e_hold && !link.copro_execute_busy;
        ld_d = ld_sw;
        st_d = lse_q ? st_q : st_sw;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dstall_q <= 1'b0;
            estall_q <= 1'b0;
            valid_q <= 1'b0;
            instr_q <= '0;
            hint_q <= 1'b0;
            cancel_q <= 1'b0;
            flush_q <= 1'b0;
            lse_q <= 1'b0;
            lsm_q <= 1'b0;
            len_q <= `CP_LEN_IDLE;
            swp_q <= 1'b0;
            dbl_q <= 1'b0;
            rej_q <= 1'b0;
            ld_q <= '0;
            st_q <= '0;
        end else begin
            dstall_q <= dstall_d;
            estall_q <= estall_d;
            valid_q <= valid_d;
            instr_q <= instr_d;
            hint_q <= hint_d;
            cancel_q <= cancel_d;
            flush_q <= flush_d;
            lse_q <= lse_d;
            lsm_q <= lsm_d;
            len_q <= len_d;
            swp_q <= swp_d;
            dbl_q <= dbl_d;
            rej_q <= rej_d;
            ld_q <= ld_d;
            st_q <= st_d;
        end
    end

    assign link.copro_instruction_bus = instr_q;
    assign link.instruction_hint_valid = hint_q;
    assign link.issue_valid_confirm = valid_q;
    assign link.core_decode_stall = dstall_q;
    assign link.core_execute_stall = estall_q;
    assign link.lsu_execute_hold = lse_q;
    assign link.lsu_memory_hold = lsm_q;
    assign link.core_cancel = cancel_q;
    assign link.core_flush = flush_q;
    assign link.load_data_bus = ld_q;
    assign attr_length = len_q;
    assign attr_swap = swp_q;
    assign attr_double = dbl_q;
    assign store_data_out = st_q;
    assign reject_seen = rej_q;
endmodule : copro_core_end
`default_nettype wire

//--- design/copro_cp_end.sv
`default_nettype none
`include "copro_defines.svh"
module copro_cp_end
    import copro_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Coprocessor user side
    input wire logic owns_ls,
    input var len_t ls_length,
    input wire logic ls_swap,
    input wire logic ls_double,
    input wire logic want_busy,
    input wire logic want_xfer_busy,
    input wire logic want_reject,
    input var dword_t store_data_in,
    input wire logic peer_xfer_busy,
    output instr_t issued_instr,
    output logic issued_strobe,
    output logic cancelled,
    output logic flushed,
    output dword_t load_data_out,
    // Link
    copro_if.copro link
);
    cp_state_e st_q, st_d;
    instr_t fetch_q, fetch_d, iss_q, iss_d;
    logic stb_q, stb_d, busy_q, busy_d, xb_q, xb_d, rej_q, rej_d, can_q, can_d, fl_q, fl_d;
    logic ls_q, ls_d;
    dword_t ld_q, ld_d;
    logic hold;

    // Only the cycle with all holds low is valid; busy here is own registered value
    assign hold = link.core_decode_stall || link.core_execute_stall || busy_q || peer_xfer_busy;

    always_comb begin
        st_d = st_q;
        fetch_d = hold ? fetch_q : link.copro_instruction_bus;
        iss_d = iss_q;
        stb_d = 1'b0;
        ls_d = ls_q;
        if (link.core_flush) begin
            st_d = CP_IDLE;
            ls_d = 1'b0;
        end else if (!hold) begin
            // Confirm is only a commitment to issue; cancel or flush may still follow
            unique case (st_q)
                CP_IDLE, CP_EXE: begin
                    st_d = link.issue_valid_confirm ? CP_DEC : CP_IDLE;
                    iss_d = fetch_q;
                    stb_d = link.issue_valid_confirm;
                    ls_d = link.issue_valid_confirm && owns_ls;
                end
                CP_DEC: begin
                    st_d = CP_EXE;
                end
            endcase
        end
        // Busy, transfer busy and reject registered from own intent (busy also cleared by flush), never from incoming holds
        busy_d = want_busy && !link.core_flush;
        xb_d = want_xfer_busy;
        rej_d = want_reject;
        can_d = link.core_cancel;
        fl_d = link.core_flush;
        ld_d = link.lsu_memory_hold ? ld_q : link.load_data_bus;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= CP_IDLE;
            fetch_q <= '0;
            iss_q <= '0;
            stb_q <= 1'b0;
            busy_q <= 1'b0;
            xb_q <= 1'b0;
            rej_q <= 1'b0;
            can_q <= 1'b0;
            fl_q <= 1'b0;
            ls_q <= 1'b0;
            ld_q <= '0;
        end else begin
            st_q <= st_d;
            fetch_q <= fetch_d;
            iss_q <= iss_d;
            stb_q <= stb_d;
            busy_q <= busy_d;
            xb_q <= xb_d;
            rej_q <= rej_d;
            can_q <= can_d;
            fl_q <= fl_d;
            ls_q <= ls_d;
            ld_q <= ld_d;
        end
    end

    // Length rides with the confirm of the issue-stage instruction, so the core can latch it before a stall
    assign link.transfer_length = (owns_ls && link.issue_valid_confirm) ? ls_length : `CP_LEN_IDLE;
    assign link.word_swap_flag = owns_ls && ls_swap;
    assign link.doubleword_flag = owns_ls && ls_double;
    assign link.copro_execute_busy = busy_q;
    assign link.copro_transfer_busy = xb_q;
    assign link.copro_reject = rej_q;
    assign link.store_data_bus = store_data_in;
    assign issued_instr = iss_q;
    assign issued_strobe = stb_q;
    assign cancelled = can_q;
    assign flushed = fl_q;
    assign load_data_out = ld_q;
endmodule : copro_cp_end
`default_nettype wire

//--- verif/copro_monitor.sv
`default_nettype none
module copro_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Link signals
    input wire logic instruction_hint_valid,
    input wire logic issue_valid_confirm,
    input wire logic core_decode_stall,
    input wire logic core_execute_stall,
    input wire logic core_cancel,
    input wire logic core_flush,
    input wire logic copro_execute_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic in_reset_q;

    // Registered copy keeps the check off the edge before reset has landed
    always_ff @(posedge clk) begin
        in_reset_q <= !rstn;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_reset_outputs_low: assert property (disable iff (1'b0) (!rstn && in_reset_q) |->
        !issue_valid_confirm && !core_decode_stall && !core_execute_stall) else $error("outputs up in reset");
    chk_confirm_after_hint: assert property ($rose(issue_valid_confirm) |-> $past(instruction_hint_valid))
        else $error("confirm without hint");
    chk_exec_needs_decode: assert property (core_execute_stall |-> core_decode_stall)
        else $error("execute stall alone");
    chk_busy_blocks_decode: assert property (($past(copro_execute_busy) && !$past(core_decode_stall))
        |-> !core_decode_stall) else $error("decode stall after busy");
    chk_busy_blocks_exec: assert property (($past(copro_execute_busy) && !$past(core_execute_stall))
        |-> !core_execute_stall) else $error("execute stall after busy");
    chk_cancel_held: assert property (core_cancel && core_execute_stall |=> core_cancel || !core_execute_stall)
        else $error("cancel dropped under stall");
    chk_flush_kills_exec: assert property (core_flush |-> !core_execute_stall)
        else $error("execute stall with flush");
    chk_flush_kills_decode: assert property (core_flush |-> !core_decode_stall)
        else $error("decode stall with flush");
endmodule : copro_monitor
`default_nettype wire

//--- verif/copro_issue_validate_and_stall_tb.sv
`default_nettype none
module copro_issue_validate_and_stall_tb;
    import copro_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rstn = 0;
    logic iv = 0, gen = 0, dh = 0, eh = 0, leh = 0, lmh = 0, lock = 0, cr = 0, fr = 0;
    logic own = 0, sw = 0, dbl = 0, wb = 0, wx = 0, wr = 0, pb = 0;
    instr_t ins = '0, iss;
    len_t len = '0, a_len;
    dword_t ldi = '0, sti = '0, sto, ldo;
    logic a_sw, a_dbl, rej, strb, canc, flu;
    int n_mismatch = 0, comparisons = 0, cycles = 0;
    copro_if link_if();
    copro_core_end i_copro_core_end (.clk(clk), .rstn(rstn), .issue_valid(iv), .issue_instr(ins),
        .decode_genuine(gen), .internal_decode_hold(dh), .execute_hold(eh), .lsu_e_hold(leh), .lsu_m_hold(lmh),
        .lockstep(lock), .cancel_req(cr), .flush_req(fr), .load_data_in(ldi), .attr_length(a_len),
        .attr_swap(a_sw), .attr_double(a_dbl), .store_data_out(sto), .reject_seen(rej), .link(link_if));
    copro_cp_end i_copro_cp_end (.clk(clk), .rstn(rstn), .owns_ls(own), .ls_length(len), .ls_swap(sw),
        .ls_double(dbl), .want_busy(wb), .want_xfer_busy(wx), .want_reject(wr), .store_data_in(sti),
        .peer_xfer_busy(pb), .issued_instr(iss), .issued_strobe(strb), .cancelled(canc), .flushed(flu),
        .load_data_out(ldo), .link(link_if));
    copro_monitor i_copro_monitor (.clk(clk), .rstn(rstn), .instruction_hint_valid(link_if.instruction_hint_valid),
        .issue_valid_confirm(link_if.issue_valid_confirm), .core_decode_stall(link_if.core_decode_stall),
        .core_execute_stall(link_if.core_execute_stall), .core_cancel(link_if.core_cancel),
        .core_flush(link_if.core_flush), .copro_execute_busy(link_if.copro_execute_busy));
    always #20 clk = ~clk;
    task automatic summarize();
        if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles > 3000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic t_issue();
        iv = 1;
        ins = 26'h2a5c3e1;
        cyc(1);
        gen = 1;
        for (int i = 0; i < 8 && strb !== 1'b1; i++) cyc(1);
        cmp(strb, 1);
        cmp(iss, 26'h2a5c3e1);
        iv = 0;
        gen = 0;
        cyc(2);
    endtask : t_issue
    task automatic t_attr();
        iv = 1; ins = 26'h0f0e0d1;
        own = 1; len = 4'h2; sw = 1; dbl = 1;
        cyc(1);
        gen = 1;
        cyc(1);
        cmp(link_if.transfer_length, 4'h2);
        cmp(link_if.doubleword_flag, 1);
        dh = 1;
        cyc(2);
        len = 4'h1; sw = 0; dbl = 0;
        cyc(1);
        cmp({a_len, a_sw, a_dbl}, {4'h2, 2'b11});
        dh = 0; iv = 0; gen = 0;
        cyc(1);
        cmp(link_if.transfer_length, 4'h0);
        own = 0;
    endtask : t_attr
    task automatic t_swap(input logic s);
        own = 1; sw = s;
        ldi = 64'h0123456789abcdef;
        sti = 64'hfedcba9876543210;
        cyc(5);
        cmp(ldo, s ? 64'h89abcdef01234567 : ldi);
        cmp(sto, s ? 64'h76543210fedcba98 : sti);
        own = 0; sw = 0;
    endtask : t_swap
    task automatic t_stalls();
        eh = 1;
        cyc(1);
        cmp({link_if.core_execute_stall, link_if.core_decode_stall}, 2'b11);
        eh = 0; dh = 1;
        cyc(1);
        cmp({link_if.core_execute_stall, link_if.core_decode_stall}, 2'b01);
        dh = 0; lock = 1; leh = 1; lmh = 1;
        cyc(1);
        cmp({link_if.core_execute_stall, link_if.core_decode_stall}, 2'b11);
        lock = 0;
        cyc(1);
        cmp({link_if.core_execute_stall, link_if.lsu_memory_hold}, 2'b01);
        lock = 1; leh = 0;
        cyc(1);
        cmp({link_if.core_execute_stall, link_if.core_decode_stall, link_if.lsu_execute_hold}, 3'b111);
        lock = 0; leh = 0; lmh = 0;
        cyc(2);
    endtask : t_stalls
    task automatic t_busy();
        wb = 1;
        cyc(2);
        eh = 1;
        cyc(2);
        cmp(link_if.core_execute_stall, 0);
        wb = 0; cr = 1;
        cyc(2);
        cr = 0;
        cyc(2);
        cmp(link_if.core_execute_stall, 1);
        cmp(link_if.core_cancel, 1);
        cmp(canc, 1);
        wr = 1;
        cyc(2);
        cmp(rej, 0);
        fr = 1;
        cyc(1);
        cmp(link_if.core_execute_stall, 0);
        fr = 0; eh = 0;
        cyc(1);
        cmp(flu, 1);
        for (int i = 0; i < 8 && rej !== 1'b1; i++) cyc(1);
        cmp(rej, 1);
        wr = 0;
        cyc(2);
    endtask : t_busy
    task automatic t_peer();
        wx = 1; pb = 1; iv = 1; ins = 26'h1b2c3d4;
        cyc(1);
        gen = 1;
        cyc(3);
        cmp(strb, 0);
        cmp(link_if.copro_transfer_busy, 1);
        wx = 0; pb = 0;
        for (int i = 0; i < 8 && strb !== 1'b1; i++) cyc(1);
        cmp(strb, 1);
        iv = 0; gen = 0;
        cyc(2);
    endtask : t_peer
    initial begin
        cyc(10);
        rstn = 1;
        cyc(1);
        t_issue();
        t_attr();
        t_swap(1);
        t_swap(0);
        t_stalls();
        t_busy();
        t_peer();
        summarize();
    end
endmodule : copro_issue_validate_and_stall_tb
`default_nettype wire
